// ==== src/csmam_pkg.sv ====
// Package: constants and types for the state, mode and address map block
package csmam_pkg;

    // Register offsets on AHB-Lite (byte addresses)
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS_WORD = 8'h04;
    localparam logic [7:0] OFS_VECTOR_BASE = 8'h08;
    localparam logic [7:0] OFS_SAVED_PC = 8'h0c;
    localparam logic [7:0] OFS_SAVED_STATUS = 8'h10;
    localparam logic [7:0] OFS_PC = 8'h14;
    localparam logic [7:0] OFS_STATE = 8'h18;
    localparam logic [7:0] OFS_ACC_RESULT = 8'h1c;

    // Status word fields
    localparam int SW_MD_POS = 30;
    localparam int SW_RB_POS = 29;
    localparam int SW_BL_POS = 28;
    localparam int SW_IMASK_LSB = 4;
    localparam logic [31:0] SW_RESET = 32'h7000_00f0;
    localparam logic [31:0] SW_RSVD_MASK = 32'h8fff_fc0c;

    // Control register fields
    localparam int CT_CACHE_EN = 0;
    localparam int CT_XLAT_EN = 1;

    localparam logic [31:0] RESET_VECTOR = 32'ha000_0000;
    localparam logic [31:0] VBR_RESET = 32'h0000_0000;
    localparam logic [31:0] PC_STEP = 32'h0000_0004;
    localparam logic [28:0] EXT_MASK = 29'h1fff_ffff;

    // Region base top bits
    localparam logic [2:0] TOP_P1 = 3'h4;
    localparam logic [2:0] TOP_P2 = 3'h5;
    localparam logic [2:0] TOP_P3 = 3'h6;
    localparam logic [2:0] TOP_P4 = 3'h7;

    typedef enum logic [1:0] {
        CSM_RESET = 2'b00,
        CSM_EXCEPT = 2'b01,
        CSM_RUN = 2'b10,
        CSM_SLEEP = 2'b11
    } csm_state_t;

    typedef enum logic [2:0] {
        CSM_RG_LOW = 3'b000,
        CSM_RG_P1 = 3'b001,
        CSM_RG_P2 = 3'b010,
        CSM_RG_P3 = 3'b011,
        CSM_RG_CTRL = 3'b100
    } csm_region_t;

    // Core event requests
    typedef struct packed {
        logic exc_req;
        logic [11:0] exc_offset;
        logic trap_req;
        logic rte_req;
        logic sleep_req;
        logic wake_req;
        logic step;
    } csm_core_t;

    // Access decode result
    typedef struct packed {
        logic valid;
        logic cacheable;
        logic translate;
        logic external;
        logic addr_err;
        csm_region_t region;
        logic [28:0] ext_addr;
    } csm_acc_t;

endpackage : csmam_pkg

// ==== src/csmam_top.sv ====
// State sequencing, mode control and address map decode
`timescale 1ns/1ps

// Operation
// - One of four processing states only
// - Power-on resets all; manual keeps control register
// - After reset fetch from A0000000
// - Exception entry saves pc and status
// - Exception fetch at vector base plus offset
// - Sleep enters low power, execution stops
// - Mode bit zero user, one privileged
// - Reset and exception entry force privileged
// - User mode blocks system ops and return
// - User to privileged via exception, trap or status word bus write
// - Return restores saved status and pc
// - Thirty-two bit space, five regions
// - Low two gigabytes cacheable, translatable
// - Cache and translate low region when enabled
// - User access upper regions raises address error
// - 80000000 region cached, direct, privileged
// - A0000000 region uncached, direct, privileged
// - C0000000 region cached, translated, privileged
// - E0000000 control region uncached, privileged
// - External address is low 29 bits
// - Control region never goes external
// - Reset values of status word, vector base
module csmam_top
    import csmam_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic manual_reset,
    input wire csm_core_t core_in,
    input wire logic acc_valid,
    input wire logic [31:0] acc_addr,
    input wire logic sys_op,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hsel,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output csm_acc_t acc_out,
    output logic [31:0] fetch_pc,
    output logic fetch_en,
    output logic priv_mode,
    output logic ill_op,
    output csm_state_t cpu_state,
    output logic [31:0] ctrl_keep
);

    csm_state_t state_q, state_d;
    logic [31:0] sw_q, vbr_q, spc_q, ssr_q, pc_q, ctrl_q;
    csm_acc_t acc_q;
    logic ill_q;
    logic [31:0] rdata_q;
    logic wr_pend_q;
    logic [7:0] wr_ofs_q;
    logic fetch_en_q;

    // AHB-Lite decode
    wire logic bus_go = hsel && hready && htrans[1];
    wire logic [7:0] bus_ofs = haddr[7:0];
    wire logic md = sw_q[SW_MD_POS];
    wire logic in_run = (state_q == CSM_RUN);
    wire logic exc_go = in_run && (core_in.exc_req || core_in.trap_req);
    wire logic rte_go = in_run && core_in.rte_req && md;
    wire logic sys_bad = in_run && !md && (sys_op || core_in.rte_req);
    wire logic sleep_go = in_run && core_in.sleep_req && md;

    // Region decode
    function automatic csm_region_t region_of(input logic [31:0] a);
        unique case (a[31:29])
            TOP_P1: region_of = CSM_RG_P1;
            TOP_P2: region_of = CSM_RG_P2;
            TOP_P3: region_of = CSM_RG_P3;
            TOP_P4: region_of = CSM_RG_CTRL;
            default: region_of = CSM_RG_LOW;
        endcase
    endfunction : region_of

    wire csm_region_t rg = region_of(acc_addr);
    wire logic rg_low = (rg == CSM_RG_LOW);
    wire logic rg_err = !md && !rg_low;
    wire logic rg_cach = (rg_low || rg == CSM_RG_P1 || rg == CSM_RG_P3)
        && ctrl_q[CT_CACHE_EN];
    wire logic rg_xlat = (rg_low || rg == CSM_RG_P3)
        && ctrl_q[CT_XLAT_EN];
    wire logic rg_ext = (rg != CSM_RG_CTRL);

    // Processing state machine
    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            CSM_RESET: state_d = CSM_RUN;
            CSM_EXCEPT: state_d = CSM_RUN;
            CSM_RUN:
            begin
                if (exc_go || sys_bad)
                    state_d = CSM_EXCEPT;
                else if (sleep_go)
                    state_d = CSM_SLEEP;
            end
            CSM_SLEEP:
            begin
                if (core_in.exc_req)
                    state_d = CSM_EXCEPT;
                else if (core_in.wake_req)
                    state_d = CSM_RUN;
            end
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset || manual_reset)
            state_q <= CSM_RESET;
        else
            state_q <= state_d;
    end

    wire logic exc_enter = (state_d == CSM_EXCEPT) && (state_q != CSM_EXCEPT);
    wire logic [31:0] sw_wr = (hwdata & ~SW_RSVD_MASK);
    wire logic sw_bus = wr_pend_q && wr_ofs_q == OFS_STATUS_WORD;

    // Status word, pc and save registers
    always_ff @(posedge clk_sys)
    begin
        if (reset || manual_reset)
        begin
            sw_q <= SW_RESET;
            vbr_q <= VBR_RESET;
            pc_q <= RESET_VECTOR;
            spc_q <= 32'h0000_0000;
            ssr_q <= 32'h0000_0000;
        end
        else if (exc_enter)
        begin
            spc_q <= pc_q;
            ssr_q <= sw_q;
            sw_q <= sw_q | SW_RESET;
            pc_q <= vbr_q + {20'h0_0000, core_in.exc_offset};
        end
        else if (rte_go)
        begin
            sw_q <= ssr_q;
            pc_q <= spc_q;
        end
        else
        begin
            if (sw_bus)
                sw_q <= sw_wr;
            if (wr_pend_q && wr_ofs_q == OFS_VECTOR_BASE)
                vbr_q <= hwdata;
            if (wr_pend_q && wr_ofs_q == OFS_SAVED_PC)
                spc_q <= hwdata;
            if (wr_pend_q && wr_ofs_q == OFS_SAVED_STATUS)
                ssr_q <= hwdata & ~SW_RSVD_MASK;
            if (in_run && core_in.step)
                pc_q <= pc_q + PC_STEP;
        end
    end

    // Control register kept over manual reset
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            ctrl_q <= 32'h0000_0000;
        else if (wr_pend_q && wr_ofs_q == OFS_CTRL)
            ctrl_q <= hwdata;
    end

    // Access result, faults not forwarded
    always_ff @(posedge clk_sys)
    begin
        if (reset || manual_reset)
        begin
            acc_q <= '0;
            ill_q <= 1'b0;
        end
        else
        begin
            acc_q.valid <= acc_valid && !rg_err;
            acc_q.cacheable <= acc_valid && !rg_err && rg_cach;
            acc_q.translate <= acc_valid && !rg_err && rg_xlat;
            acc_q.external <= acc_valid && !rg_err && rg_ext;
            acc_q.addr_err <= acc_valid && rg_err;
            acc_q.region <= rg;
            acc_q.ext_addr <= acc_addr[28:0] & EXT_MASK;
            ill_q <= sys_bad;
        end
    end

    // Fetch enable, registered from next state
    always_ff @(posedge clk_sys)
    begin
        if (reset || manual_reset)
            fetch_en_q <= 1'b0;
        else
            fetch_en_q <= (state_d == CSM_RUN) || (state_d == CSM_EXCEPT);
    end

    // AHB-Lite slave, zero wait states
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            wr_pend_q <= 1'b0;
            wr_ofs_q <= 8'h00;
            rdata_q <= 32'h0000_0000;
        end
        else
        begin
            wr_pend_q <= bus_go && hwrite;
            wr_ofs_q <= bus_ofs;
            if (bus_go && !hwrite)
            begin
                unique case (bus_ofs)
                    OFS_CTRL: rdata_q <= ctrl_q;
                    OFS_STATUS_WORD: rdata_q <= sw_q;
                    OFS_VECTOR_BASE: rdata_q <= vbr_q;
                    OFS_SAVED_PC: rdata_q <= spc_q;
                    OFS_SAVED_STATUS: rdata_q <= ssr_q;
                    OFS_PC: rdata_q <= pc_q;
                    OFS_STATE: rdata_q <= {30'h0, state_q};
                    OFS_ACC_RESULT: rdata_q <= {27'h0, acc_q.addr_err,
                        acc_q.external, acc_q.translate, acc_q.cacheable,
                        acc_q.valid};
                    default: rdata_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign hrdata = rdata_q;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign acc_out = acc_q;
    assign fetch_pc = pc_q;
    assign fetch_en = fetch_en_q;
    assign priv_mode = md;
    assign ill_op = ill_q;
    assign cpu_state = state_q;
    assign ctrl_keep = ctrl_q;

    a_reset_fetch_vec: assert property (@(posedge clk_sys)
        $fell(reset) && !manual_reset |-> pc_q == RESET_VECTOR)
        else $error("pc not at reset vector");

    a_exc_save_pc: assert property (@(posedge clk_sys) disable iff (reset)
        exc_enter && !manual_reset |=> spc_q == $past(pc_q))
        else $error("pc not saved");

    a_exc_vector: assert property (@(posedge clk_sys) disable iff (reset)
        exc_enter && !manual_reset |=> pc_q == $past(vbr_q)
        + {20'h0_0000, $past(core_in.exc_offset)})
        else $error("bad exception vector");

    a_exc_priv: assert property (@(posedge clk_sys) disable iff (reset)
        state_q == CSM_EXCEPT |-> md)
        else $error("exception not privileged");

    a_user_err: assert property (@(posedge clk_sys) disable iff (reset)
        acc_valid && !md && acc_addr[31] && !manual_reset
        |=> acc_q.addr_err && !acc_q.valid && !acc_q.external)
        else $error("user upper access not faulted");

    a_ctrl_no_ext: assert property (@(posedge clk_sys) disable iff (reset)
        acc_q.external |-> acc_q.region != CSM_RG_CTRL)
        else $error("control region went external");

    a_rte_restore: assert property (@(posedge clk_sys) disable iff (reset)
        rte_go && !exc_enter && !manual_reset
        |=> sw_q == $past(ssr_q) && pc_q == $past(spc_q))
        else $error("return did not restore");

    a_sleep_stop: assert property (@(posedge clk_sys) disable iff (reset)
        state_q == CSM_SLEEP |-> !fetch_en)
        else $error("fetch during sleep");

    // State and reset checks
    a_reset_to_run: assert property (@(posedge clk_sys) disable iff (reset)
        state_q == CSM_RESET && !manual_reset |=> state_q == CSM_RUN)
        else $error("reset state did not end");

    a_manual_sw: assert property (@(posedge clk_sys) disable iff (reset)
        manual_reset |=> sw_q == SW_RESET && vbr_q == VBR_RESET)
        else $error("manual reset values wrong");

    a_manual_pc: assert property (@(posedge clk_sys) disable iff (reset)
        manual_reset |=> pc_q == RESET_VECTOR)
        else $error("manual reset pc wrong");

    a_manual_ctrl: assert property (@(posedge clk_sys) disable iff (reset)
        manual_reset && !(wr_pend_q && wr_ofs_q == OFS_CTRL)
        |=> ctrl_q == $past(ctrl_q))
        else $error("control lost on manual reset");

    // Exception and mode checks
    a_exc_save_sw: assert property (@(posedge clk_sys) disable iff (reset)
        exc_enter && !manual_reset |=> ssr_q == $past(sw_q))
        else $error("status not saved");

    a_exc_md_set: assert property (@(posedge clk_sys) disable iff (reset)
        exc_enter && !manual_reset
        |=> md && sw_q[SW_RB_POS] && sw_q[SW_BL_POS])
        else $error("entry bits not set");

    a_sleep_enter: assert property (@(posedge clk_sys) disable iff (reset)
        sleep_go && !exc_go && !manual_reset
        |=> state_q == CSM_SLEEP)
        else $error("sleep not entered");

    a_user_sys_op: assert property (@(posedge clk_sys) disable iff (reset)
        sys_bad && !manual_reset
        |=> ill_q && state_q == CSM_EXCEPT)
        else $error("user system op not refused");

    a_user_stays: assert property (@(posedge clk_sys) disable iff (reset)
        !md && !exc_enter && !sw_bus && !manual_reset |=> !md)
        else $error("privilege gained without exception");

    a_trap_enter: assert property (@(posedge clk_sys) disable iff (reset)
        in_run && core_in.trap_req && !manual_reset
        |=> state_q == CSM_EXCEPT && md)
        else $error("trap not taken");

    // Address map checks
    a_low_attr: assert property (@(posedge clk_sys) disable iff (reset)
        acc_valid && !acc_addr[31] && !manual_reset
        |=> acc_q.valid && acc_q.region == CSM_RG_LOW
        && acc_q.cacheable == $past(ctrl_q[CT_CACHE_EN])
        && acc_q.translate == $past(ctrl_q[CT_XLAT_EN]))
        else $error("low region attributes wrong");

    a_p1_attr: assert property (@(posedge clk_sys) disable iff (reset)
        acc_valid && md && acc_addr[31:29] == TOP_P1 && !manual_reset
        |=> acc_q.region == CSM_RG_P1 && !acc_q.translate
        && acc_q.external)
        else $error("cached direct attributes wrong");

    a_p2_attr: assert property (@(posedge clk_sys) disable iff (reset)
        acc_valid && md && acc_addr[31:29] == TOP_P2 && !manual_reset
        |=> acc_q.region == CSM_RG_P2 && !acc_q.cacheable
        && !acc_q.translate && acc_q.external)
        else $error("uncached direct attributes wrong");

    a_p3_attr: assert property (@(posedge clk_sys) disable iff (reset)
        acc_valid && md && acc_addr[31:29] == TOP_P3 && !manual_reset
        |=> acc_q.region == CSM_RG_P3
        && acc_q.translate == $past(ctrl_q[CT_XLAT_EN]))
        else $error("mapped high attributes wrong");

    a_ctrl_attr: assert property (@(posedge clk_sys) disable iff (reset)
        acc_valid && md && acc_addr[31:29] == TOP_P4 && !manual_reset
        |=> acc_q.valid && !acc_q.cacheable && !acc_q.translate
        && !acc_q.external)
        else $error("control region attributes wrong");

    a_ext_addr: assert property (@(posedge clk_sys) disable iff (reset)
        acc_valid && !manual_reset
        |=> acc_q.ext_addr == $past(acc_addr[28:0]))
        else $error("external address wrong");

    a_fault_quiet: assert property (@(posedge clk_sys) disable iff (reset)
        acc_q.addr_err |-> !acc_q.cacheable && !acc_q.translate)
        else $error("faulting access forwarded");

    a_region_ctrl: assert property (@(posedge clk_sys) disable iff (reset)
        acc_valid && acc_addr[31:29] == TOP_P4 && !manual_reset
        |=> acc_q.region == CSM_RG_CTRL)
        else $error("region decode wrong");


endmodule : csmam_top

// ==== bench/csmam_far_side.sv ====
// Far side model: bus controller view of forwarded accesses
`timescale 1ns/1ps
module csmam_far_side
    import csmam_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire csm_acc_t acc_out,
    output logic [31:0] ext_count,
    output logic [28:0] last_ext
);
    wire logic take;
    assign take = acc_out.valid & acc_out.external;
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            ext_count <= '0;
            last_ext <= '0;
        end
        else if (take)
        begin
            ext_count <= ext_count + 32'h0000_0001;
            last_ext <= acc_out.ext_addr;
        end
    end
endmodule : csmam_far_side

// ==== bench/tb.sv ====
// Testbench for the state, mode and address map block
`timescale 1ns/1ps
module tb;
    import csmam_pkg::*;
    logic clk_sys, reset, manual_reset, acc_valid, sys_op, hwrite, hsel;
    logic hreadyout, hresp, fetch_en, priv_mode, ill_op;
    logic [31:0] acc_addr, hwdata, haddr, hrdata, fetch_pc, ctrl_keep;
    logic [31:0] ext_count, c0, rd;
    logic [28:0] last_ext;
    logic [1:0] htrans;
    logic [2:0] hsize;
    csm_core_t core_in;
    csm_acc_t acc_out;
    csm_state_t cpu_state;
    int fails, num_checks, k;
    logic [31:0] ra[5] = '{32'h0000_0100, 32'h8000_0100, 32'ha000_0100,
        32'hc000_0100, 32'he000_0100};
    logic [7:0] re[5] = '{8'hf0, 8'hd1, 8'h92, 8'hf3, 8'h84};
    csmam_top i_csmam_top (.clk_sys(clk_sys), .reset(reset),
        .manual_reset(manual_reset), .core_in(core_in),
        .acc_valid(acc_valid), .acc_addr(acc_addr), .sys_op(sys_op),
        .hwdata(hwdata), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hsel(hsel), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .acc_out(acc_out),
        .fetch_pc(fetch_pc), .fetch_en(fetch_en), .priv_mode(priv_mode),
        .ill_op(ill_op), .cpu_state(cpu_state), .ctrl_keep(ctrl_keep));
    csmam_far_side i_csmam_far_side (.clk_sys(clk_sys), .reset(reset),
        .acc_out(acc_out), .ext_count(ext_count), .last_ext(last_ext));
    initial
    begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    task automatic chk(input string nm, input logic [31:0] e, g);
        num_checks++;
        if (g !== e)
        begin
            fails++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic end_of_test;
        $display("Checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : end_of_test
    task automatic bus(input logic wr, input logic [7:0] a,
        input logic [31:0] wd);
        htrans <= 2'b10;
        haddr <= {24'h00_0000, a};
        hwrite <= wr;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        rd = hrdata;
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask : bus
    task automatic rchk(input string nm, input logic [7:0] a,
        input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(nm, e, rd);
    endtask : rchk
    task automatic ev(input csm_core_t c, input logic [1:0] st);
        core_in <= c;
        @(posedge clk_sys);
        core_in <= '0;
        #1 chk("state", {30'h0, st}, {30'h0, cpu_state});
        repeat (2) @(posedge clk_sys);
    endtask : ev
    task automatic acc(input logic [31:0] a, input logic [7:0] e, m);
        acc_valid <= 1'b1;
        acc_addr <= a;
        @(posedge clk_sys);
        acc_valid <= 1'b0;
        #1 chk("acc", {24'h0, e & m}, {24'h0, acc_out[36:29] & m});
        if (e[4])
            chk("ext_addr", {3'h0, a[28:0]}, {3'h0, acc_out.ext_addr});
        @(posedge clk_sys);
    endtask : acc
    initial
    begin
        repeat (5000) @(posedge clk_sys);
        fails++;
        end_of_test();
    end
    initial
    begin
        {reset, manual_reset, acc_valid, sys_op, hwrite} = '0;
        reset = 1'b1;
        {acc_addr, hwdata, haddr, htrans, core_in} = '0;
        hsel = 1'b1;
        hsize = 3'h2;
        repeat (4) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        #1 chk("state", 32'h2, {30'h0, cpu_state});
        chk("fetch_pc", 32'ha000_0000, fetch_pc);
        @(posedge clk_sys);
        rchk("sw", OFS_STATUS_WORD, 32'h7000_00f0);
        rchk("vbr", OFS_VECTOR_BASE, 32'h0000_0000);
        rchk("pc", OFS_PC, 32'ha000_0000);
        rchk("unmapped", 8'h40, 32'h0000_0000);
        bus(1'b1, OFS_CTRL, 32'h0000_0000);
        acc(ra[0], 8'h90, 8'hff);
        bus(1'b1, OFS_CTRL, 32'h0000_0003);
        for (k = 0; k < 5; k++)
            acc(ra[k], re[k], 8'hff);
        chk("last_ext", 32'h0000_0100, {3'h0, last_ext});
        acc(ra[2], 8'h92, 8'hff);
        bus(1'b1, OFS_VECTOR_BASE, 32'h0000_1000);
        ev('{exc_req: 1'b1, exc_offset: 12'h100, default: '0}, 2'h1);
        rchk("spc", OFS_SAVED_PC, 32'ha000_0000);
        rchk("ssr", OFS_SAVED_STATUS, 32'h7000_00f0);
        rchk("pc", OFS_PC, 32'h0000_1100);
        bus(1'b1, OFS_STATUS_WORD, 32'h0fff_ffff);
        rchk("sw", OFS_STATUS_WORD, 32'h0000_03f3);
        chk("priv", 32'h0, {31'h0, priv_mode});
        c0 = ext_count;
        acc(ra[2], 8'h08, 8'h78);
        acc(ra[4], 8'h08, 8'h78);
        chk("ext_count", c0, ext_count);
        acc(ra[0], 8'hf0, 8'hff);
        sys_op <= 1'b1;
        @(posedge clk_sys);
        sys_op <= 1'b0;
        #1 k = int'(ill_op === 1'b1);
        repeat (2)
        begin
            @(posedge clk_sys);
            #1 k += int'(ill_op === 1'b1);
        end
        chk("ill_op", 32'h1, k);
        @(posedge clk_sys);
        chk("priv", 32'h1, {31'h0, priv_mode});
        rchk("ssr", OFS_SAVED_STATUS, 32'h0000_03f3);
        rchk("spc", OFS_SAVED_PC, 32'h0000_1100);
        ev('{rte_req: 1'b1, default: '0}, 2'h2);
        chk("priv", 32'h0, {31'h0, priv_mode});
        rchk("pc", OFS_PC, 32'h0000_1100);
        ev('{trap_req: 1'b1, default: '0}, 2'h1);
        chk("priv", 32'h1, {31'h0, priv_mode});
        rchk("ssr", OFS_SAVED_STATUS, 32'h0000_03f3);
        ev('{sleep_req: 1'b1, default: '0}, 2'h3);
        chk("fetch_en", 32'h0, {31'h0, fetch_en});
        ev('{wake_req: 1'b1, default: '0}, 2'h2);
        manual_reset <= 1'b1;
        @(posedge clk_sys);
        manual_reset <= 1'b0;
        repeat (2) @(posedge clk_sys);
        chk("ctrl_keep", 32'h0000_0003, ctrl_keep);
        rchk("sw", OFS_STATUS_WORD, 32'h7000_00f0);
        rchk("vbr", OFS_VECTOR_BASE, 32'h0000_0000);
        rchk("pc", OFS_PC, 32'ha000_0000);
        end_of_test();
    end
endmodule : tb
